// ### hw/tws_regs.svh
// Register map, field positions and timing counts of the two-wire status block.
// Assumes a 40 MHz system clock and an APB slave with byte addresses.
//
// Notes on behaviour
// RQ1: At the end of each acknowledge slot of a master transmit the sampled line is kept, one for NACK, zero for ACK.
// RQ2: The master transmit flag rises when a master byte starts and falls at the end of the slave acknowledge.
// RQ3: A collision seen during a master operation sets the collision flag, which software can clear but not set.
// RQ4: The general call flag is set when the general call address arrives and cleared when a Stop is seen.
// RQ5: The ten-bit match flag is set when the second byte of a matching ten-bit address arrives and cleared at Stop.
// RQ6: A write to the transmit holding register while busy is refused and sets a sticky write collision flag.
// RQ7: A byte that must go to a still full receive buffer sets an overflow flag that only software clears.
// RQ8: As a slave the data/address indicator clears on an own address match and sets when a data byte arrives.
// RQ9: Start or Repeated Start sets the start indicator and clears the stop one, and Stop does the reverse.
// RQ10: After a matching address byte the slave keeps the direction bit, one for read and zero for write.
// RQ11: Receive buffer full rises when a byte is written into the buffer and falls when software reads it.
// RQ12: Transmit buffer full rises when software writes the holding register and falls when that byte is sent.
// RQ13: A ten-bit address mask excludes each set position from the slave address comparison.
// RQ14: Reception is double-buffered and each byte moved into the buffer raises an interrupt event.
// RQ15: With general call enabled the general call address raises an interrupt, otherwise it is ignored.
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define TWS_OFF_STAT 8'h00
`define TWS_OFF_MASK 8'h04
`define TWS_OFF_TXH 8'h08
`define TWS_OFF_RXB 8'h0C
`define TWS_OFF_CTRL 8'h10
`define TWS_OFF_ISTAT 8'h14
`define TWS_OFF_IMASK 8'h18

// ****************************************
// Status fields
// ****************************************
`define TWS_ST_ACK 15
`define TWS_ST_TRS 14
`define TWS_ST_BCL 10
`define TWS_ST_GC 9
`define TWS_ST_A10 8
`define TWS_ST_IWC 7
`define TWS_ST_OV 6
`define TWS_ST_DA 5
`define TWS_ST_P 4
`define TWS_ST_S 3
`define TWS_ST_RW 2
`define TWS_ST_RBF 1
`define TWS_ST_TBF 0

// ****************************************
// Control, interrupt and address fields
// ****************************************
`define TWS_CT_TEN 10
`define TWS_CT_GENERAL_CALL_ENABLE 11
`define TWS_CT_MST 12
`define TWS_CT_W 13
`define TWS_CT_RST 13'h0000
`define TWS_IRQ_W 6
`define TWS_IRQ_RX 0
`define TWS_IRQ_GC 1
`define TWS_IRQ_BCL 2
`define TWS_IRQ_IWC 3
`define TWS_IRQ_OV 4
`define TWS_IRQ_DONE 5
`define TWS_GC_ADDR 8'h00
`define TWS_TEN_PREFIX 5'h1E
`define TWS_ACK_BIT 4'h8
`define TWS_BYTE_BITS 4'h8

// ****************************************
// Timing
// ****************************************
`define TWS_MCLK_NS 25
`define TWS_HALF_NS 5000

`endif

// ### hw/tws_pkg.sv
// Types shared by the two-wire status block.
// Assumes nothing beyond a SystemVerilog compiler.
package tws_pkg;
	// Synchronised line levels and detected bus events
	typedef struct packed {
		logic scl;
		logic sda;
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
	} tws_line_s;

	// Slave receive states, Gray along the usual path
	typedef enum logic [1:0] {SL_IDLE = 2'b00, SL_RECV = 2'b01, SL_ACK = 2'b11, SL_SKIP = 2'b10} tws_slave_e;

	// Master transmit states, Gray except the return from M_HIGH to M_IDLE
	typedef enum logic [1:0] {M_IDLE = 2'b00, M_LOW = 2'b01, M_HIGH = 2'b11} tws_master_e;
endpackage : tws_pkg

// ### hw/tws_line_sync.sv
// Two-flop synchronisers for the bus lines plus edge and condition detection.
// Assumes the bus lines are asynchronous to the system clock.
`timescale 1ns/100ps
module tws_line_sync
	import tws_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output tws_line_s line
);
	logic [1:0] meta_reg;
	logic [1:0] sync_reg;
	logic [1:0] prev_reg;

	// Two stages; the first is read only by the second
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_reg <= 2'h3;
			sync_reg <= 2'h3;
			prev_reg <= 2'h3;
		end else begin
			meta_reg <= {scl_in, sda_in};
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	// Registered levels and events
	always_ff @(posedge clk) begin
		if (rst) begin
			line <= '{scl: 1'b1, sda: 1'b1, default: 1'b0};
		end else begin
			line.scl <= sync_reg[1];
			line.sda <= sync_reg[0];
			line.scl_rise <= sync_reg[1] & ~prev_reg[1];
			line.scl_fall <= ~sync_reg[1] & prev_reg[1];
			line.start <= sync_reg[1] & prev_reg[1] & prev_reg[0] & ~sync_reg[0];
			line.stop <= sync_reg[1] & prev_reg[1] & ~prev_reg[0] & sync_reg[0];
		end
	end
endmodule : tws_line_sync

// ### hw/tws_status.sv
// Status flags, address mask, slave receiver and master byte transmitter of the two-wire controller.
// Assumes an APB master on MCLK and open-drain SCL/SDA pins resolved outside.
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/100ps
`include "tws_regs.svh"
module tws_status
	import tws_pkg::*;
#(
	parameter int HALF_CYCLES = (`TWS_HALF_NS + `TWS_MCLK_NS - 1) / `TWS_MCLK_NS
)
(
	input wire logic MCLK,
	input wire logic SYS_RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic SCL_IN,
	output logic SCL_OUT,
	output logic SCL_OE_N,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE_N,
	output logic IRQ
);
	// ****************************************
	// Helpers
	// ****************************************
	// Masked compare: set mask bits drop out of the comparison
	function automatic logic addr_match(input logic [9:0] a, input logic [9:0] b, input logic [9:0] m);
		addr_match = ((a ^ b) & ~m) == 10'h000;
	endfunction : addr_match

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = a == off;
	endfunction : hit

	// ****************************************
	// Declarations
	// ****************************************
	tws_line_s line;
	tws_slave_e sl_state_reg;
	tws_master_e m_state_reg;
	logic [`TWS_CT_W-1:0] ctrl_reg;
	logic [9:0] addr_mask_reg;
	logic [7:0] tx_hold_reg;
	logic [7:0] rx_buf_reg;
	logic [7:0] sl_shift_reg;
	logic [3:0] sl_bits_reg;
	logic [1:0] sl_byte_reg;
	logic sl_ack_reg;
	logic [7:0] m_shift_reg;
	logic [3:0] m_bits_reg;
	logic [15:0] m_div_reg;
	logic ack_received_status_reg, master_tx_in_progress_reg, bus_collision_flag_reg;
	logic general_call_received_reg, ten_bit_addr_matched_reg, write_collision_flag_reg;
	logic receive_overflow_flag_reg, data_not_addr_reg, stop_seen_reg, start_seen_reg;
	logic read_not_write_reg, rx_buffer_full_reg, tx_buffer_full_reg;
	logic [`TWS_IRQ_W-1:0] irq_stat_reg, irq_mask_reg, irq_ev;
	logic [15:0] stat_word;
	logic wr, rd, mapped, wr_stat, busy, txh_try, txh_ok;
	logic byte_done, gc_hit, a7_hit, a10_hi, a10_lo, data_byte, dev_match;
	logic rx_load, ov_ev, m_go, m_tick, m_end, m_end_ack, bcl_ev;

	// ****************************************
	// Line synchroniser
	// ****************************************
	tws_line_sync u_sync (
		.clk(MCLK),
		.rst(SYS_RST),
		.scl_in(SCL_IN),
		.sda_in(SDA_IN),
		.line(line)
	);

	// ****************************************
	// APB decode
	// ****************************************
	// Zero wait states, error on unmapped words
	assign wr = PSEL & PENABLE & PWRITE;
	assign rd = PSEL & PENABLE & ~PWRITE;
	assign mapped = hit(PADDR, `TWS_OFF_STAT) | hit(PADDR, `TWS_OFF_MASK) | hit(PADDR, `TWS_OFF_TXH)
		| hit(PADDR, `TWS_OFF_RXB) | hit(PADDR, `TWS_OFF_CTRL) | hit(PADDR, `TWS_OFF_ISTAT)
		| hit(PADDR, `TWS_OFF_IMASK);
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL & PENABLE & ~mapped;
	assign wr_stat = wr & hit(PADDR, `TWS_OFF_STAT);
	assign busy = tx_buffer_full_reg | (m_state_reg != M_IDLE);
	assign txh_try = wr & hit(PADDR, `TWS_OFF_TXH);
	assign txh_ok = txh_try & ~busy;

	// Status word as software sees it
	always_comb begin
		stat_word = 16'h0000;
		stat_word[`TWS_ST_ACK] = ack_received_status_reg;
		stat_word[`TWS_ST_TRS] = master_tx_in_progress_reg;
		stat_word[`TWS_ST_BCL] = bus_collision_flag_reg;
		stat_word[`TWS_ST_GC] = general_call_received_reg;
		stat_word[`TWS_ST_A10] = ten_bit_addr_matched_reg;
		stat_word[`TWS_ST_IWC] = write_collision_flag_reg;
		stat_word[`TWS_ST_OV] = receive_overflow_flag_reg;
		stat_word[`TWS_ST_DA] = data_not_addr_reg;
		stat_word[`TWS_ST_P] = stop_seen_reg;
		stat_word[`TWS_ST_S] = start_seen_reg;
		stat_word[`TWS_ST_RW] = read_not_write_reg;
		stat_word[`TWS_ST_RBF] = rx_buffer_full_reg;
		stat_word[`TWS_ST_TBF] = tx_buffer_full_reg;
	end

	// Read data captured in the setup cycle
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			PRDATA <= 32'h00000000;
		end else if (PSEL & ~PENABLE & ~PWRITE) begin
			unique case (PADDR)
				`TWS_OFF_STAT: PRDATA <= {16'h0000, stat_word};
				`TWS_OFF_MASK: PRDATA <= {22'h000000, addr_mask_reg};
				`TWS_OFF_TXH: PRDATA <= {24'h000000, tx_hold_reg};
				`TWS_OFF_RXB: PRDATA <= {24'h000000, rx_buf_reg};
				`TWS_OFF_CTRL: PRDATA <= {19'h00000, ctrl_reg};
				`TWS_OFF_ISTAT: PRDATA <= {26'h0000000, irq_stat_reg};
				`TWS_OFF_IMASK: PRDATA <= {26'h0000000, irq_mask_reg};
				default: PRDATA <= 32'h00000000;
			endcase
		end
	end

	// Software-written configuration and holding register
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			ctrl_reg <= `TWS_CT_RST;
			addr_mask_reg <= 10'h000;
			irq_mask_reg <= '0;
			tx_hold_reg <= 8'h00;
		end else begin
			if (wr & hit(PADDR, `TWS_OFF_CTRL))
				ctrl_reg <= PWDATA[`TWS_CT_W-1:0];
			if (wr & hit(PADDR, `TWS_OFF_MASK))
				addr_mask_reg <= PWDATA[9:0]; // RQ13
			if (wr & hit(PADDR, `TWS_OFF_IMASK))
				irq_mask_reg <= PWDATA[`TWS_IRQ_W-1:0];
			if (txh_ok)
				tx_hold_reg <= PWDATA[7:0]; // RQ6
		end
	end

	// ****************************************
	// Slave address decode
	// ****************************************
	assign byte_done = (sl_state_reg == SL_RECV) & line.scl_fall & (sl_bits_reg == `TWS_BYTE_BITS);
	assign gc_hit = (sl_byte_reg == 2'd0) & (sl_shift_reg == `TWS_GC_ADDR) & ctrl_reg[`TWS_CT_GENERAL_CALL_ENABLE]; // RQ15
	assign a7_hit = (sl_byte_reg == 2'd0) & ~ctrl_reg[`TWS_CT_TEN] & ~gc_hit
		& addr_match({3'h0, sl_shift_reg[7:1]}, {3'h0, ctrl_reg[6:0]}, addr_mask_reg); // RQ13
	assign a10_hi = (sl_byte_reg == 2'd0) & ctrl_reg[`TWS_CT_TEN] & (sl_shift_reg[7:3] == `TWS_TEN_PREFIX)
		& addr_match({8'h00, sl_shift_reg[2:1]}, {8'h00, ctrl_reg[9:8]}, {8'h00, addr_mask_reg[9:8]});
	assign a10_lo = (sl_byte_reg == 2'd1)
		& addr_match({2'h0, sl_shift_reg}, {2'h0, ctrl_reg[7:0]}, {2'h0, addr_mask_reg[7:0]});
	assign data_byte = sl_byte_reg == 2'd2;
	assign dev_match = byte_done & (a7_hit | a10_lo);
	assign rx_load = byte_done & data_byte & ~rx_buffer_full_reg;
	assign ov_ev = byte_done & data_byte & rx_buffer_full_reg;

	// Slave receive sequencer
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			sl_state_reg <= SL_IDLE;
			sl_shift_reg <= 8'h00;
			sl_bits_reg <= 4'h0;
			sl_byte_reg <= 2'd0;
			sl_ack_reg <= 1'b0;
		end else if (line.stop) begin
			sl_state_reg <= SL_IDLE;
		end else if (line.start) begin
			sl_state_reg <= SL_RECV;
			sl_bits_reg <= 4'h0;
			sl_byte_reg <= 2'd0;
		end else begin
			unique case (sl_state_reg)
				SL_IDLE: sl_ack_reg <= 1'b0;
				SL_RECV: begin
					if (line.scl_rise & (sl_bits_reg != `TWS_BYTE_BITS)) begin
						sl_shift_reg <= {sl_shift_reg[6:0], line.sda};
						sl_bits_reg <= sl_bits_reg + 4'h1;
					end
					if (byte_done) begin
						sl_ack_reg <= gc_hit | a7_hit | a10_hi | a10_lo | rx_load;
						sl_state_reg <= (gc_hit | a7_hit | a10_hi | a10_lo | rx_load) ? SL_ACK : SL_SKIP;
						sl_byte_reg <= a10_hi ? 2'd1 : 2'd2;
					end
				end
				SL_ACK: begin
					if (line.scl_fall) begin
						sl_ack_reg <= 1'b0;
						sl_bits_reg <= 4'h0;
						sl_state_reg <= read_not_write_reg ? SL_SKIP : SL_RECV;
					end
				end
				SL_SKIP: sl_ack_reg <= 1'b0;
			endcase
		end
	end

	// Receive buffer, filled from the shift register
	always_ff @(posedge MCLK) begin
		if (SYS_RST)
			rx_buf_reg <= 8'h00;
		else if (rx_load)
			rx_buf_reg <= sl_shift_reg; // RQ14
	end

	// ****************************************
	// Master byte transmitter
	// ****************************************
	assign m_go = (m_state_reg == M_IDLE) & tx_buffer_full_reg & ctrl_reg[`TWS_CT_MST];
	assign m_tick = (m_state_reg != M_IDLE) & (m_div_reg == 16'(HALF_CYCLES - 1));
	assign m_end = m_tick & (m_state_reg == M_HIGH);
	assign m_end_ack = m_end & (m_bits_reg == `TWS_ACK_BIT);
	assign bcl_ev = m_end & (m_bits_reg != `TWS_ACK_BIT) & m_shift_reg[7] & ~line.sda; // RQ3

	// Divider; the high half waits for SCL to be seen high
	always_ff @(posedge MCLK) begin
		if (SYS_RST | m_tick | (m_state_reg == M_IDLE))
			m_div_reg <= 16'h0000;
		else if ((m_state_reg == M_LOW) | line.scl)
			m_div_reg <= m_div_reg + 16'h0001;
	end

	// Bit sequencer: eight data bits then the acknowledge slot
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			m_state_reg <= M_IDLE;
			m_shift_reg <= 8'h00;
			m_bits_reg <= 4'h0;
		end else if (m_go) begin
			m_state_reg <= M_LOW;
			m_shift_reg <= tx_hold_reg;
			m_bits_reg <= 4'h0;
		end else if (m_tick) begin
			unique case (m_state_reg)
				M_LOW: m_state_reg <= M_HIGH;
				M_HIGH: begin
					if (m_end_ack | bcl_ev) begin
						m_state_reg <= M_IDLE;
					end else begin
						m_state_reg <= M_LOW;
						m_shift_reg <= {m_shift_reg[6:0], 1'b1};
						m_bits_reg <= m_bits_reg + 4'h1;
					end
				end
				default: m_state_reg <= M_IDLE;
			endcase
		end
	end

	// Pin drivers, open drain with active-low enables
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			SCL_OE_N <= 1'b1;
			SDA_OE_N <= 1'b1;
		end else begin
			SCL_OE_N <= m_state_reg != M_LOW;
			SDA_OE_N <= ~(sl_ack_reg | ((m_state_reg != M_IDLE) & (m_bits_reg != `TWS_ACK_BIT) & ~m_shift_reg[7]));
		end
	end
	assign SCL_OUT = 1'b0;
	assign SDA_OUT = 1'b0;

	// ****************************************
	// Status flags; a hardware set beats a software clear
	// ****************************************
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			ack_received_status_reg <= 1'b0;
			master_tx_in_progress_reg <= 1'b0;
		end else begin
			if (m_end_ack)
				ack_received_status_reg <= line.sda; // RQ1
			if (m_go)
				master_tx_in_progress_reg <= 1'b1; // RQ2
			else if (m_end_ack | bcl_ev)
				master_tx_in_progress_reg <= 1'b0; // RQ2
		end
	end

	// Clear-only flags, cleared by writing zero
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			bus_collision_flag_reg <= 1'b0;
			write_collision_flag_reg <= 1'b0;
			receive_overflow_flag_reg <= 1'b0;
		end else begin
			if (bcl_ev)
				bus_collision_flag_reg <= 1'b1; // RQ3
			else if (wr_stat & ~PWDATA[`TWS_ST_BCL])
				bus_collision_flag_reg <= 1'b0;
			if (txh_try & busy)
				write_collision_flag_reg <= 1'b1; // RQ6
			else if (wr_stat & ~PWDATA[`TWS_ST_IWC])
				write_collision_flag_reg <= 1'b0;
			if (ov_ev)
				receive_overflow_flag_reg <= 1'b1; // RQ7
			else if (wr_stat & ~PWDATA[`TWS_ST_OV])
				receive_overflow_flag_reg <= 1'b0;
		end
	end

	// Address-phase flags
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			general_call_received_reg <= 1'b0;
			ten_bit_addr_matched_reg <= 1'b0;
			data_not_addr_reg <= 1'b0;
			read_not_write_reg <= 1'b0;
		end else begin
			if (byte_done & gc_hit)
				general_call_received_reg <= 1'b1; // RQ4
			else if (line.stop)
				general_call_received_reg <= 1'b0; // RQ4
			if (byte_done & a10_lo)
				ten_bit_addr_matched_reg <= 1'b1; // RQ5
			else if (line.stop)
				ten_bit_addr_matched_reg <= 1'b0; // RQ5
			if (dev_match)
				data_not_addr_reg <= 1'b0; // RQ8
			else if (byte_done & data_byte)
				data_not_addr_reg <= 1'b1; // RQ8
			if (byte_done & (a7_hit | a10_hi | gc_hit))
				read_not_write_reg <= sl_shift_reg[0]; // RQ10
		end
	end

	// Start/stop indicators, also clearable by software
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			start_seen_reg <= 1'b0;
			stop_seen_reg <= 1'b0;
		end else if (line.start | line.stop) begin
			start_seen_reg <= line.start; // RQ9
			stop_seen_reg <= line.stop; // RQ9
		end else if (wr_stat) begin
			start_seen_reg <= start_seen_reg & PWDATA[`TWS_ST_S];
			stop_seen_reg <= stop_seen_reg & PWDATA[`TWS_ST_P];
		end
	end

	// Buffer-full flags
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			rx_buffer_full_reg <= 1'b0;
			tx_buffer_full_reg <= 1'b0;
		end else begin
			if (rx_load)
				rx_buffer_full_reg <= 1'b1; // RQ11
			else if (rd & hit(PADDR, `TWS_OFF_RXB))
				rx_buffer_full_reg <= 1'b0; // RQ11
			if (txh_ok)
				tx_buffer_full_reg <= 1'b1; // RQ12
			else if (m_end_ack | bcl_ev)
				tx_buffer_full_reg <= 1'b0; // RQ12
		end
	end

	// ****************************************
	// Interrupts: sticky events, write one to clear
	// ****************************************
	always_comb begin
		irq_ev = '0;
		irq_ev[`TWS_IRQ_RX] = rx_load; // RQ14
		irq_ev[`TWS_IRQ_GC] = byte_done & gc_hit; // RQ15
		irq_ev[`TWS_IRQ_BCL] = bcl_ev;
		irq_ev[`TWS_IRQ_IWC] = txh_try & busy;
		irq_ev[`TWS_IRQ_OV] = ov_ev;
		irq_ev[`TWS_IRQ_DONE] = m_end_ack;
	end

	always_ff @(posedge MCLK) begin
		if (SYS_RST)
			irq_stat_reg <= '0;
		else if (wr & hit(PADDR, `TWS_OFF_ISTAT))
			irq_stat_reg <= (irq_stat_reg & ~PWDATA[`TWS_IRQ_W-1:0]) | irq_ev;
		else
			irq_stat_reg <= irq_stat_reg | irq_ev;
	end

	assign IRQ = |(irq_stat_reg & irq_mask_reg);

	// ****************************************
	// Checks
	// ****************************************
	sequence s_byte_start;
		m_go ##1 master_tx_in_progress_reg;
	endsequence

	sequence s_ack_slot;
		(m_state_reg == M_HIGH) && (m_bits_reg == `TWS_ACK_BIT);
	endsequence

	a_ack_capture: assert property (@(posedge MCLK) disable iff (SYS_RST) // RQ1
		s_ack_slot ##0 m_tick |=> ack_received_status_reg == $past(line.sda)) else $error("ack status not captured");
	a_master_tx_in_progress_rise: assert property (@(posedge MCLK) disable iff (SYS_RST) // RQ2
		m_go |-> s_byte_start) else $error("master_tx_in_progress not raised");
	a_master_tx_in_progress_span: assert property (@(posedge MCLK) disable iff (SYS_RST) // RQ2
		(m_state_reg != M_IDLE) |-> master_tx_in_progress_reg) else $error("master_tx_in_progress dropped early");
	a_master_tx_in_progress_end: assert property (@(posedge MCLK) disable iff (SYS_RST) // RQ2
		m_end_ack |=> !master_tx_in_progress_reg && !tx_buffer_full_reg) else $error("master_tx_in_progress not cleared");
	a_bcl_sticky: assert property (@(posedge MCLK) disable iff (SYS_RST) // RQ3
		bcl_ev |=> bus_collision_flag_reg && m_state_reg == M_IDLE) else $error("collision not flagged");
	a_gc_stop: assert property (@(posedge MCLK) disable iff (SYS_RST) // RQ4
		line.stop && !byte_done |=> !general_call_received_reg && !ten_bit_addr_matched_reg) else $error("stop clear");
	a_ten_bit: assert property (@(posedge MCLK) disable iff (SYS_RST) // RQ5
		byte_done && a10_lo && !line.stop |=> ten_bit_addr_matched_reg && !data_not_addr_reg) else $error("ten-bit");
	a_write_coll: assert property (@(posedge MCLK) disable iff (SYS_RST) // RQ6
		txh_try && busy |=> write_collision_flag_reg && $stable(tx_hold_reg)) else $error("busy write accepted");
	a_rx_overflow: assert property (@(posedge MCLK) disable iff (SYS_RST) // RQ7
		ov_ev |=> receive_overflow_flag_reg && $stable(rx_buf_reg)) else $error("overflow not flagged");
	a_start_stop: assert property (@(posedge MCLK) disable iff (SYS_RST) // RQ9
		line.start |=> start_seen_reg && !stop_seen_reg) else $error("start indicator wrong");
	a_rw_capture: assert property (@(posedge MCLK) disable iff (SYS_RST) // RQ10
		byte_done && a7_hit |=> read_not_write_reg == $past(sl_shift_reg[0]) ##0 sl_state_reg == SL_ACK)
		else $error("direction not captured");
	a_rbf_read: assert property (@(posedge MCLK) disable iff (SYS_RST) // RQ11
		rd && PADDR == `TWS_OFF_RXB && !rx_load |=> !rx_buffer_full_reg) else $error("rbf not cleared by read");
	a_rx_move: assert property (@(posedge MCLK) disable iff (SYS_RST) // RQ14
		rx_load |=> rx_buf_reg == $past(sl_shift_reg) && irq_stat_reg[`TWS_IRQ_RX] && rx_buffer_full_reg)
		else $error("rx byte not moved");
	a_gc_irq: assert property (@(posedge MCLK) disable iff (SYS_RST) // RQ15
		byte_done && sl_byte_reg == 2'd0 && sl_shift_reg == `TWS_GC_ADDR && !ctrl_reg[`TWS_CT_GENERAL_CALL_ENABLE]
		|=> !general_call_received_reg || $past(general_call_received_reg)) else $error("general call not ignored");
endmodule : tws_status

// ### tb/tws_partner.sv
// Far side of the two-wire bus: a master that frames bytes and a slave that acknowledges.
// Assumes pull-ups, so a released line reads one; inputs are the resolved wire levels.
`timescale 1ns/100ps
// ****************************************
// Bus partner
// ****************************************
module tws_partner (
	input wire logic scl,
	input wire logic sda,
	output logic scl_o,
	output logic sda_o
);
	logic sda_m = 1'b1;
	logic armed = 1'b0;
	logic ack_en = 1'b0;
	logic clash = 1'b0;
	int cnt = 0;
	logic [7:0] rx = 8'h00;
	// Clock stands high outside frames
	initial scl_o = 1'b1;
	// While armed, the slave pulls data low in its ack slot, or all the time when told to clash
	assign sda_o = sda_m & ~(armed & (((cnt == 9) & ack_en) | clash));
	// Count clock falls while armed
	always @(negedge scl or negedge armed) begin
		cnt <= armed ? cnt + 1 : 0;
	end
	// Gather the eight data bits
	always @(posedge scl) begin
		if (armed && cnt < 9) begin
			rx <= {rx[6:0], sda};
		end
	end
	// One bit: long low half so the block's late ack release lands before SCL rises
	task automatic bit_io(input logic b, output logic s);
		scl_o = 1'b0;
		#100 sda_m = b;
		#50 scl_o = 1'b1;
		#25 s = sda;
		#25;
	endtask : bit_io
	task automatic start;
		#7 sda_m = 1'b0;
		#100;
	endtask : start
	// Byte MSB first, then the ack slot with data released
	task automatic send(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
		end
		bit_io(1'b1, ack);
	endtask : send
	task automatic stop;
		scl_o = 1'b0;
		#50 sda_m = 1'b0;
		#50 scl_o = 1'b1;
		#100 sda_m = 1'b1;
		#100;
	endtask : stop
endmodule : tws_partner

// ### tb/tb_top.sv
// Self-checking bench of the two-wire status block: APB master, bus partner, queued checks.
// Assumes the design's register map header and the partner model on the resolved lines.
`timescale 1ns/100ps
`include "tws_regs.svh"
`define CHK(g, e, m) begin samples_checked++; if (((g) & (m)) !== ((e) & (m))) begin fails++; \
	$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
// ****************************************
// Bench top
// ****************************************
module tb_top;
	logic MCLK = 1'b0;
	logic SYS_RST = 1'b1;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0, PRDATA;
	logic PREADY, PSLVERR, SCL_OUT, SCL_OE_N, SDA_OUT, SDA_OE_N, IRQ, scl_p, sda_p, ack;
	wire scl = (SCL_OE_N | SCL_OUT) & scl_p;
	wire sda = (SDA_OE_N | SDA_OUT) & sda_p;
	int fails = 0, samples_checked = 0;
	logic [32:0] exp_q[$], msk_q[$], got_q[$], g, e, m, r;
	logic [7:0] d;
	// Clock at 40 MHz
	always #12.5 MCLK = ~MCLK;
	tws_status #(.HALF_CYCLES(4)) dut (.MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.SCL_IN(scl), .SCL_OUT(SCL_OUT), .SCL_OE_N(SCL_OE_N), .SDA_IN(sda), .SDA_OUT(SDA_OUT),
		.SDA_OE_N(SDA_OE_N), .IRQ(IRQ));
	tws_partner p (.scl(scl), .sda(sda), .scl_o(scl_p), .sda_o(sda_p));
	// Note an expectation with the result it belongs to
	task automatic post(input logic [32:0] ev, mv, gv);
		exp_q.push_back(ev);
		msk_q.push_back(mv);
		got_q.push_back(gv);
	endtask : post
	// One APB transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge MCLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= wd;
		@(posedge MCLK);
		PENABLE <= 1'b1;
		do @(posedge MCLK); while (PREADY !== 1'b1);
		r = {PSLVERR, PRDATA};
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] ev, mv);
		apb(1'b0, a, 32'h0);
		post({1'b0, ev}, {1'b1, mv}, r);
	endtask : rd
	task automatic st(input logic [31:0] ev, mv);
		rd(`TWS_OFF_STAT, ev, mv);
	endtask : st
	task automatic irq(input logic ev);
		@(negedge MCLK);
		post(ev, 1, IRQ);
	endtask : irq
	// Wait for the partner slave to count a tenth clock fall, which never comes after the ack slot, so 400 clocks, then 8 more
	task automatic mwait;
		for (int i = 0; i < 400 && p.cnt < 10; i++) @(posedge MCLK);
		repeat (8) @(posedge MCLK);
	endtask : mwait
	// Take the oldest note whenever a result is waiting
	always @(posedge MCLK) begin
		while (got_q.size() > 0) begin
			g = got_q.pop_front();
			e = exp_q.pop_front();
			m = msk_q.pop_front();
			`CHK(g, e, m)
		end
	end
	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : finish_test
	// Cut a hang short
	initial begin
		#400000;
		fails++;
		finish_test();
	end
	// Main sequence
	initial begin
		void'($urandom(50));
		repeat (12) @(posedge MCLK);
		SYS_RST <= 1'b0;
		st(32'h0, 32'hFFFFFFFF);
		rd(`TWS_OFF_MASK, 32'h0, 32'hFFFFFFFF);
		apb(1'b0, 8'h1C, 32'h0);
		post({1'b1, 32'h0}, {33{1'b1}}, r);
		apb(1'b1, `TWS_OFF_MASK, 32'hFFFFFFFF);
		rd(`TWS_OFF_MASK, 32'h3FF, 32'hFFFFFFFF);
		apb(1'b1, `TWS_OFF_MASK, 32'h1);
		apb(1'b1, `TWS_OFF_CTRL, 32'h52);
		apb(1'b1, `TWS_OFF_IMASK, 32'h3F);
		$display("end registers");
		p.start();
		p.send(8'hA6, ack);
		post(0, 1, ack);
		st(32'h8, 32'h3C);
		d = 8'($urandom);
		p.send(d, ack);
		post(0, 1, ack);
		st(32'h22, 32'h62);
		rd(`TWS_OFF_ISTAT, 32'h1, 32'h1);
		irq(1'b1);
		p.send(~d, ack);
		post(1, 1, ack);
		st(32'h40, 32'h40);
		rd(`TWS_OFF_RXB, {24'h0, d}, 32'hFFFFFFFF);
		st(32'h40, 32'h42);
		apb(1'b1, `TWS_OFF_STAT, 32'h0);
		st(32'h0, 32'h40);
		p.stop();
		st(32'h10, 32'h18);
		apb(1'b1, `TWS_OFF_ISTAT, 32'h3F);
		p.start();
		p.send(8'hAD, ack);
		post(1, 1, ack);
		p.stop();
		p.start();
		p.send(8'h00, ack);
		post(1, 1, ack);
		p.stop();
		p.start();
		p.send(8'hA7, ack);
		st(32'h4, 32'h4);
		p.stop();
		$display("end slave receive");
		apb(1'b1, `TWS_OFF_CTRL, 32'h852);
		p.start();
		p.send(8'h00, ack);
		post(0, 1, ack);
		st(32'h200, 32'h200);
		rd(`TWS_OFF_ISTAT, 32'h2, 32'h2);
		irq(1'b1);
		apb(1'b1, `TWS_OFF_IMASK, 32'h0);
		irq(1'b0);
		apb(1'b1, `TWS_OFF_IMASK, 32'h3F);
		apb(1'b1, `TWS_OFF_ISTAT, 32'h3F);
		irq(1'b0);
		p.stop();
		st(32'h0, 32'h200);
		apb(1'b1, `TWS_OFF_CTRL, 32'h6A5);
		p.start();
		p.send(8'hF4, ack);
		p.send(8'hA5, ack);
		st(32'h100, 32'h100);
		p.stop();
		st(32'h0, 32'h100);
		$display("end address modes");
		apb(1'b1, `TWS_OFF_CTRL, 32'h1000);
		p.ack_en = 1'b1;
		p.armed = 1'b1;
		d = 8'($urandom);
		apb(1'b1, `TWS_OFF_TXH, {24'h0, d});
		st(32'h4001, 32'h4001);
		apb(1'b1, `TWS_OFF_TXH, 32'h0);
		st(32'h80, 32'h80);
		mwait();
		st(32'h80, 32'hC081);
		post(d, 32'hFF, p.rx);
		p.armed = 1'b0;
		p.ack_en = 1'b0;
		#1 p.armed = 1'b1;
		apb(1'b1, `TWS_OFF_TXH, 32'h5A);
		mwait();
		st(32'h8000, 32'h8000);
		p.armed = 1'b0;
		p.clash = 1'b1;
		#1 p.armed = 1'b1;
		apb(1'b1, `TWS_OFF_TXH, 32'hA5);
		repeat (60) @(posedge MCLK);
		st(32'h400, 32'h4401);
		rd(`TWS_OFF_ISTAT, 32'h4, 32'h4);
		p.armed = 1'b0;
		apb(1'b1, `TWS_OFF_STAT, 32'hFFFF);
		st(32'h400, 32'h400);
		apb(1'b1, `TWS_OFF_STAT, 32'h0);
		apb(1'b1, `TWS_OFF_STAT, 32'hFFFF);
		st(32'h0, 32'h400);
		$display("end master transmit");
		repeat (2) @(posedge MCLK);
		finish_test();
	end
endmodule : tb_top
